// ==== core/adc_conversion_ctrl.sv ====
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_ctrl
  import adc_ctrl_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RC_CLOCK_I,
  input wire logic COMPARE_I,
  input wire logic SLEEP_I,
  input wire logic IRQ_ENABLE_I,
  input wire logic SPECIAL_TRIGGER_I,
  output logic CONVERTER_POWER_O,
  output logic SAMPLE_O,
  output logic [9:0] DAC_CODE_O,
  output logic [7:0] EXT_INPUT_SEL_O,
  output logic [2:0] INTERNAL_SEL_O,
  output logic REF_EXTERNAL_O,
  output logic TIMER_RESET_O,
  output logic WAKE_O,
  output logic DONE_FLAG_O
);

  // ==========================================================
  // state
  // ==========================================================
  ctrl_state_type state;
  ctrl_state_type next_state;
  logic converter_on;
  logic next_converter_on;
  logic go;
  logic next_go;
  logic result_justify;
  logic next_result_justify;
  logic positive_ref_select;
  logic next_positive_ref_select;
  logic [3:0] input_channel_select;
  logic [3:0] next_input_channel_select;
  logic [2:0] clock_divider;
  logic [2:0] next_clock_divider;
  logic done_flag;
  logic next_done_flag;
  logic [9:0] result_word;
  logic [9:0] next_result_word;
  logic [2:0] delay_count;
  logic [2:0] next_delay_count;
  logic [1:0] holdoff_count;
  logic [1:0] next_holdoff_count;
  logic pready;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_power;
  logic next_sample;
  logic [7:0] next_ext_sel;
  logic [2:0] next_int_sel;
  logic next_timer_reset;
  logic next_wake;

  // ==========================================================
  // decode of bus access
  // ==========================================================
  logic setup;
  logic write_done;
  logic ctrl_write;
  logic sw_go_set;
  logic sw_go_clear;
  logic rc_selected;
  logic start_request;
  logic sar_start;
  logic sar_abort;
  logic sar_done;
  logic [9:0] sar_trial;
  logic tad_en;
  logic [7:0] read_byte;
  logic mapped;

  // a write lands only at the edge that completes the access
  assign setup = PSEL_I & ~PENABLE_I & ~pready;
  assign write_done = PSEL_I & PENABLE_I & pready & PWRITE_I;
  assign ctrl_write = write_done & (PADDR_I == CTRL_OFFSET);
  assign sw_go_set = ctrl_write & PWDATA_I[GO_BIT];
  assign sw_go_clear = ctrl_write & ~PWDATA_I[GO_BIT];
  assign rc_selected = clock_divider[1:0] == RC_CLOCK_CODE;

  // go set needs the converter already on, so a combined write
  // only switches the converter on
  assign start_request = converter_on & (state == ACQUIRE_ST)
    & (sw_go_set | SPECIAL_TRIGGER_I);

  // ==========================================================
  // submodules
  // ==========================================================
  tad_timebase timebase
  (
    .clock_i(CLOCK_I),
    .rst_i(RST_I),
    .clk_code_i(clock_divider),
    .restart_i(sar_start),
    .rc_clock_i(RC_CLOCK_I),
    .tad_en_o(tad_en)
  );

  sar_stepper stepper
  (
    .clock_i(CLOCK_I),
    .rst_i(RST_I),
    .tad_en_i(tad_en),
    .start_i(sar_start),
    .abort_i(sar_abort),
    .compare_i(COMPARE_I),
    .trial_o(sar_trial),
    .done_o(sar_done)
  );

  assign DAC_CODE_O = sar_trial;

  // ==========================================================
  // conversion sequencing
  // ==========================================================
  // one place decides go, state and the start/abort strobes
  always_comb
  begin
    next_state = state;
    next_go = go;
    next_delay_count = delay_count;
    next_holdoff_count = holdoff_count;
    next_result_word = result_word;
    next_wake = 1'b0;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    next_done_flag = done_flag;
    if (write_done && PADDR_I == STATUS_OFFSET && PWDATA_I[DONE_BIT])
      next_done_flag = 1'b0;
    case (state)
      OFF_ST:
      begin
        next_go = 1'b0;
        if (converter_on)
          next_state = ACQUIRE_ST;
      end
      ACQUIRE_ST:
      begin
        if (SLEEP_I && !rc_selected)
          next_state = ASLEEP_ST;
        else if (start_request)
        begin
          next_go = 1'b1;
          if (rc_selected)
          begin
            // room for the sleep instruction first
            next_state = DELAY_ST;
            next_delay_count = 3'h0;
          end
          else
          begin
            next_state = CONVERT_ST;
            sar_start = 1'b1;
          end
        end
      end
      DELAY_ST:
      begin
        next_delay_count = 3'(delay_count + 3'h1);
        if (sw_go_clear)
        begin
          next_go = 1'b0;
          next_state = HOLDOFF_ST;
          next_holdoff_count = 2'h0;
        end
        else if (delay_count == 3'(INSTR_CYCLE_CLOCKS - 1))
        begin
          next_state = CONVERT_ST;
          sar_start = 1'b1;
        end
      end
      CONVERT_ST:
      begin
        // completion beats a clear landing in the same cycle
        if (sar_done)
        begin
          next_go = 1'b0;
          next_done_flag = 1'b1;
          next_result_word = sar_trial;
          next_wake = SLEEP_I & IRQ_ENABLE_I;
          if (SLEEP_I && !IRQ_ENABLE_I)
            next_state = ASLEEP_ST;
          else
            next_state = ACQUIRE_ST;
        end
        else if (SLEEP_I && !rc_selected)
        begin
          sar_abort = 1'b1;
          next_go = 1'b0;
          next_state = ASLEEP_ST;
        end
        else if (sw_go_clear)
        begin
          sar_abort = 1'b1;
          next_go = 1'b0;
          next_state = HOLDOFF_ST;
          next_holdoff_count = 2'h0;
        end
      end
      HOLDOFF_ST:
      begin
        if (tad_en)
          next_holdoff_count = 2'(holdoff_count + 2'h1);
        if (holdoff_count == HOLDOFF_TADS)
          next_state = ACQUIRE_ST;
      end
      ASLEEP_ST:
      begin
        if (!SLEEP_I)
          next_state = ACQUIRE_ST;
      end
      default:
      begin
        next_state = OFF_ST;
        next_go = 1'b0;
      end
    endcase
    // converter_on low forces OFF_ST and clears go at once, and aborts a conversion unless it completes in that cycle
    if (!converter_on)
    begin
      next_state = OFF_ST;
      next_go = 1'b0;
      sar_abort = (state == CONVERT_ST) & ~sar_done;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      state <= OFF_ST;
      go <= 1'b0;
      delay_count <= 3'h0;
      holdoff_count <= 2'h0;
      result_word <= RESULT_RESET;
      done_flag <= 1'b0;
      WAKE_O <= 1'b0;
    end
    else
    begin
      state <= next_state;
      go <= next_go;
      delay_count <= next_delay_count;
      holdoff_count <= next_holdoff_count;
      result_word <= next_result_word;
      done_flag <= next_done_flag;
      WAKE_O <= next_wake;
    end
  end

  // ==========================================================
  // configuration registers
  // ==========================================================
  always_comb
  begin
    next_converter_on = converter_on;
    next_result_justify = result_justify;
    next_positive_ref_select = positive_ref_select;
    next_input_channel_select = input_channel_select;
    next_clock_divider = clock_divider;
    if (ctrl_write)
    begin
      next_converter_on = PWDATA_I[ON_BIT];
      next_result_justify = PWDATA_I[JUSTIFY_BIT];
      next_positive_ref_select = PWDATA_I[REF_BIT];
      next_input_channel_select = PWDATA_I[CHAN_LSB +: 4];
    end
    if (write_done && PADDR_I == CLKSEL_OFFSET)
      next_clock_divider = PWDATA_I[CLKDIV_LSB +: 3];
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      converter_on <= CTRL_RESET[ON_BIT];
      result_justify <= CTRL_RESET[JUSTIFY_BIT];
      positive_ref_select <= CTRL_RESET[REF_BIT];
      input_channel_select <= CTRL_RESET[CHAN_LSB +: 4];
      clock_divider <= CLKSEL_RESET;
    end
    else
    begin
      converter_on <= next_converter_on;
      result_justify <= next_result_justify;
      positive_ref_select <= next_positive_ref_select;
      input_channel_select <= next_input_channel_select;
      clock_divider <= next_clock_divider;
    end
  end

  // ==========================================================
  // register read and bus answer
  // ==========================================================
  // result layout follows the justify bit at read time
  always_comb
  begin
    mapped = 1'b1;
    read_byte = 8'h00;
    case (PADDR_I)
      CTRL_OFFSET:
        read_byte = {result_justify, positive_ref_select,
          input_channel_select, go, converter_on};
      CLKSEL_OFFSET:
        read_byte = {1'b0, clock_divider, 4'h0};
      RESULT_HIGH_OFFSET:
        if (result_justify)
          read_byte = {6'h00, result_word[9:8]};
        else
          read_byte = result_word[9:2];
      RESULT_LOW_OFFSET:
        if (result_justify)
          read_byte = result_word[7:0];
        else
          read_byte = {result_word[1:0], 6'h00};
      STATUS_OFFSET:
        read_byte = {7'h00, done_flag};
      default:
        mapped = 1'b0;
    endcase
    // zero wait states: ready rises in the access cycle
    next_pready = setup;
    next_prdata = setup ? {24'h000000, read_byte} : 32'h00000000;
    next_pslverr = setup & ~mapped;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      pready <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
      PRDATA_O <= next_prdata;
      PSLVERR_O <= next_pslverr;
    end
  end

  assign PREADY_O = pready;

  // ==========================================================
  // analog side controls, all registered
  // ==========================================================
  // reserved channel codes connect nothing to the sampler
  always_comb
  begin
    next_ext_sel = 8'h00;
    if (!input_channel_select[3])
      next_ext_sel[input_channel_select[2:0]] = 1'b1;
    next_int_sel = {input_channel_select == FIXED_HIGH_CHANNEL,
      input_channel_select == FIXED_LOW_CHANNEL,
      input_channel_select == LADDER_CHANNEL};
    next_power = converter_on & (next_state != OFF_ST)
      & (next_state != ASLEEP_ST);
    next_sample = (next_state == ACQUIRE_ST)
      | (next_state == DELAY_ST);
    next_timer_reset = SPECIAL_TRIGGER_I;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      CONVERTER_POWER_O <= 1'b0;
      SAMPLE_O <= 1'b0;
      EXT_INPUT_SEL_O <= 8'h00;
      INTERNAL_SEL_O <= 3'h0;
      REF_EXTERNAL_O <= 1'b0;
      TIMER_RESET_O <= 1'b0;
      DONE_FLAG_O <= 1'b0;
    end
    else
    begin
      CONVERTER_POWER_O <= next_power;
      SAMPLE_O <= next_sample;
      EXT_INPUT_SEL_O <= next_ext_sel;
      INTERNAL_SEL_O <= next_int_sel;
      REF_EXTERNAL_O <= positive_ref_select;
      TIMER_RESET_O <= next_timer_reset;
      DONE_FLAG_O <= next_done_flag;
    end
  end

endmodule : adc_conversion_ctrl
`default_nettype wire

// ==== shared/adc_ctrl_pkg.sv ====
// ============================================================
// constants and types shared by the conversion control block
// ============================================================
package adc_ctrl_pkg;

  // system clock and instruction cycle timing
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int INSTR_CYCLE_CLOCKS =
    (INSTR_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CLKSEL_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h08;
  localparam logic [7:0] RESULT_LOW_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  // field positions
  localparam int ON_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHAN_LSB = 2;
  localparam int REF_BIT = 6;
  localparam int JUSTIFY_BIT = 7;
  localparam int CLKDIV_LSB = 4;
  localparam int DONE_BIT = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // conversion figures
  localparam int RESULT_BITS = 10;
  localparam logic [3:0] CONVERSION_TADS = 4'hB;
  localparam logic [1:0] HOLDOFF_TADS = 2'h2;
  localparam logic [9:0] FIRST_TRIAL = 10'h200;
  localparam logic [1:0] RC_CLOCK_CODE = 2'h3;

  // channel codes of the internal sources
  localparam logic [3:0] LADDER_CHANNEL = 4'hC;
  localparam logic [3:0] FIXED_LOW_CHANNEL = 4'hD;
  localparam logic [3:0] FIXED_HIGH_CHANNEL = 4'hE;

  typedef enum logic [2:0] {
    OFF_ST,
    ACQUIRE_ST,
    DELAY_ST,
    CONVERT_ST,
    HOLDOFF_ST,
    ASLEEP_ST
  } ctrl_state_type;

endpackage : adc_ctrl_pkg

// ==== core/tad_timebase.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bit conversion period enable from divider or rc clock pin
// ============================================================
module tad_timebase
  import adc_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [2:0] clk_code_i,
  input wire logic restart_i,
  input wire logic rc_clock_i,
  output logic tad_en_o
);

  logic [1:0] rc_sync;
  logic [1:0] next_rc_sync;
  logic rc_prev;
  logic next_rc_prev;
  logic [5:0] count;
  logic [5:0] next_count;
  logic next_tad_en;
  logic [2:0] shift;
  logic [5:0] mask;

  // code order maps to a power of two: 000,100,001,101,010,110
  assign shift = 3'({clk_code_i[1:0], clk_code_i[2]} + 3'h1);
  assign mask = 6'((7'h01 << shift) - 7'h01);

  // rc pin passes two flops before the edge detector reads it
  always_comb
  begin
    next_rc_sync = {rc_sync[0], rc_clock_i};
    next_rc_prev = rc_sync[1];
    next_count = restart_i ? 6'h00 : 6'(count + 6'h01);
    if (clk_code_i[1:0] == RC_CLOCK_CODE)
      next_tad_en = rc_sync[1] & ~rc_prev;
    else
      next_tad_en = ~restart_i & ((count & mask) == mask);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rc_sync <= 2'h0;
      rc_prev <= 1'b0;
      count <= 6'h00;
      tad_en_o <= 1'b0;
    end
    else
    begin
      rc_sync <= next_rc_sync;
      rc_prev <= next_rc_prev;
      count <= next_count;
      tad_en_o <= next_tad_en;
    end
  end

endmodule : tad_timebase
`default_nettype wire

// ==== core/sar_stepper.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// successive approximation stepper, one step per bit period
// ============================================================
module sar_stepper
  import adc_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tad_en_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic compare_i,
  output logic [9:0] trial_o,
  output logic done_o
);

  logic [1:0] cmp_sync;
  logic [1:0] next_cmp_sync;
  logic active;
  logic next_active;
  logic [3:0] step;
  logic [3:0] next_step;
  logic [9:0] next_trial;
  logic next_done;
  logic [3:0] idx;

  assign idx = 4'(4'hA - step);

  // step 0 is the hold period, steps 1..10 decide bits 9..0
  always_comb
  begin
    next_cmp_sync = {cmp_sync[0], compare_i};
    next_active = active;
    next_step = step;
    next_trial = trial_o;
    next_done = 1'b0;
    if (abort_i)
      next_active = 1'b0;
    else if (start_i)
    begin
      next_active = 1'b1;
      next_step = 4'h0;
      next_trial = FIRST_TRIAL;
    end
    else if (active && tad_en_i)
    begin
      next_step = 4'(step + 4'h1);
      if (step != 4'h0)
      begin
        for (int i = 0; i < RESULT_BITS; i++)
        begin
          if (4'(i) == idx)
            next_trial[i] = cmp_sync[1];
          if (4'(i + 1) == idx)
            next_trial[i] = 1'b1;
        end
      end
      // last step: eleven periods in all
      if (step == 4'(CONVERSION_TADS - 4'h1))
      begin
        next_done = 1'b1;
        next_active = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cmp_sync <= 2'h0;
      active <= 1'b0;
      step <= 4'h0;
      trial_o <= 10'h000;
      done_o <= 1'b0;
    end
    else
    begin
      cmp_sync <= next_cmp_sync;
      active <= next_active;
      step <= next_step;
      trial_o <= next_trial;
      done_o <= next_done;
    end
  end

endmodule : sar_stepper
`default_nettype wire

// ==== verif/adc_analog_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// comparator of the analog core facing the trial code
// ============================================================
module adc_analog_model
(
  input wire logic clock_i,
  input wire logic power_i,
  input wire logic [9:0] level_i,
  input wire logic [9:0] code_i,
  output logic compare_o
);
  logic churn = 1'b0;
  // an unpowered comparator must not hand out a steady, lucky answer
  always @(posedge clock_i)
    churn <= ~churn;
  // keep the trial bit while the held level is at or above the code
  assign compare_o = power_i ? (level_i >= code_i) : churn;
endmodule : adc_analog_model
`default_nettype wire

// ==== verif/adc_ctrl_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// port checks of the conversion control block
// ============================================================
module adc_ctrl_props
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic SLEEP_I,
  input wire logic IRQ_ENABLE_I,
  input wire logic SPECIAL_TRIGGER_I,
  input wire logic CONVERTER_POWER_O,
  input wire logic SAMPLE_O,
  input wire logic [7:0] EXT_INPUT_SEL_O,
  input wire logic [2:0] INTERNAL_SEL_O,
  input wire logic TIMER_RESET_O,
  input wire logic WAKE_O,
  input wire logic DONE_FLAG_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // bus answers: one access cycle, error only with ready
  property p_ready;
    PSEL_I && !PENABLE_I |=> PREADY_O;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err;
    PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I;
  endproperty
  a_err: assert property (p_err) else $error("stray bus error");
  property p_upper;
    PRDATA_O[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  // trigger and timer reset travel together
  property p_trig;
    SPECIAL_TRIGGER_I |=> TIMER_RESET_O;
  endproperty
  a_trig: assert property (p_trig) else $error("no timer reset");
  property p_trig_only;
    TIMER_RESET_O |-> $past(SPECIAL_TRIGGER_I);
  endproperty
  a_trig_only: assert property (p_trig_only) else $error("stray reset");
  property p_wake;
    WAKE_O |-> $past(SLEEP_I) && $past(IRQ_ENABLE_I) && DONE_FLAG_O;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  property p_off;
    !CONVERTER_POWER_O |-> !SAMPLE_O;
  endproperty
  a_off: assert property (p_off) else $error("sampling unpowered");
  property p_sel;
    $onehot0({EXT_INPUT_SEL_O, INTERNAL_SEL_O});
  endproperty
  a_sel: assert property (p_sel) else $error("two inputs selected");
  property p_reset;
    $fell(RST_I) |-> !CONVERTER_POWER_O && !DONE_FLAG_O && !PREADY_O;
  endproperty
  a_reset: assert property (p_reset) else $error("state after reset");
  // only a bus access may take the done flag down
  property p_done_hold;
    DONE_FLAG_O && !(PSEL_I && PENABLE_I) |=> DONE_FLAG_O;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("flag lost");
  c_wake: cover property (WAKE_O);
  c_trig: cover property (TIMER_RESET_O);
  c_done: cover property ($rose(DONE_FLAG_O));
  c_err: cover property (PSLVERR_O);
endmodule : adc_ctrl_props
bind adc_conversion_ctrl adc_ctrl_props chk (.CLOCK_I(CLOCK_I),
  .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .SLEEP_I(SLEEP_I), .IRQ_ENABLE_I(IRQ_ENABLE_I),
  .SPECIAL_TRIGGER_I(SPECIAL_TRIGGER_I),
  .CONVERTER_POWER_O(CONVERTER_POWER_O), .SAMPLE_O(SAMPLE_O),
  .EXT_INPUT_SEL_O(EXT_INPUT_SEL_O), .INTERNAL_SEL_O(INTERNAL_SEL_O),
  .TIMER_RESET_O(TIMER_RESET_O), .WAKE_O(WAKE_O),
  .DONE_FLAG_O(DONE_FLAG_O));
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import adc_ctrl_pkg::*;
;
  typedef struct packed {
    logic [9:0] lvl;
    logic [7:0] ctl;
    logic [2:0] ck;
    logic [6:0] div;
    logic [7:0] ext;
    logic [2:0] isel;
    logic [7:0] hi;
    logic [7:0] lo;
  } row_type;
  // level, control, clock code, divide, selects, result bytes
  row_type rows [6] = '{
    '{10'h3FF, 8'h81, 3'h1, 7'h08, 8'h01, 3'h0, 8'h03, 8'hFF},
    '{10'h155, 8'h5D, 3'h5, 7'h10, 8'h80, 3'h0, 8'h55, 8'h40},
    '{10'h2AA, 8'hB1, 3'h2, 7'h20, 8'h00, 3'h1, 8'h02, 8'hAA},
    '{10'h001, 8'h75, 3'h6, 7'h40, 8'h00, 3'h2, 8'h00, 8'h40},
    '{10'h200, 8'hF9, 3'h7, 7'h00, 8'h00, 3'h4, 8'h02, 8'h00},
    '{10'h0C3, 8'h0D, 3'h4, 7'h04, 8'h08, 3'h0, 8'h30, 8'hC0}};
  logic [7:0] regs [4] = '{CTRL_OFFSET, CLKSEL_OFFSET, STATUS_OFFSET,
    RESULT_HIGH_OFFSET};
  logic clock, rst, psel, penable, pwrite, rc, sleep, irq, trig, cmp;
  logic pready, pslverr, power, sample, refx, tres, wake, done, rerr;
  logic [7:0] paddr, ext;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0] level, dac;
  logic [2:0] intl;
  int n_mismatch, checks_done, n;
  // ==========================================================
  // clocks, design and analog core
  // ==========================================================
  always #25 clock = ~clock;
  // the rc oscillator runs free, out of step with the system clock
  always #1013 rc = ~rc;
  adc_conversion_ctrl uut (.CLOCK_I(clock), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .RC_CLOCK_I(rc), .COMPARE_I(cmp),
    .SLEEP_I(sleep), .IRQ_ENABLE_I(irq), .SPECIAL_TRIGGER_I(trig),
    .CONVERTER_POWER_O(power), .SAMPLE_O(sample), .DAC_CODE_O(dac),
    .EXT_INPUT_SEL_O(ext), .INTERNAL_SEL_O(intl), .REF_EXTERNAL_O(refx),
    .TIMER_RESET_O(tres), .WAKE_O(wake), .DONE_FLAG_O(done));
  adc_analog_model analog (.clock_i(clock), .power_i(power),
    .level_i(level), .code_i(dac), .compare_o(cmp));
  // ==========================================================
  // bus cycles and waits
  // ==========================================================
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  // values read right after an edge are the settled pre-edge ones
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 20);
    if (k == 20)
      n_mismatch++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wdone(output int k);
    k = 0;
    while (done !== 1'b1 && k < 3000)
    begin
      tick(1);
      k++;
    end
    if (k == 3000)
      n_mismatch++;
  endtask : wdone
  task automatic chkreset;
    foreach (regs[k])
    begin
      apb(1'b0, regs[k], 8'h00);
      `CHK(rdata, 32'h00000000)
    end
  endtask : chkreset
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // watchdog and main sequence
  // ==========================================================
  initial
  begin
    tick(60000);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    {clock, rst, rc} = 3'b010;
    {psel, penable, pwrite, sleep, irq, trig} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    level = 10'h000;
    tick(10);
    rst <= 1'b0;
    chkreset();
    foreach (rows[i])
    begin
      level <= rows[i].lvl;
      apb(1'b1, CLKSEL_OFFSET, {1'b0, rows[i].ck, 4'h0});
      apb(1'b1, CTRL_OFFSET, rows[i].ctl);
      tick(20);
      `CHK(ext, rows[i].ext)
      `CHK(intl, rows[i].isel)
      `CHK(refx, rows[i].ctl[6])
      apb(1'b1, CTRL_OFFSET, rows[i].ctl | 8'h02);
      apb(1'b0, CTRL_OFFSET, 8'h00);
      `CHK(rdata[1], 1'b1)
      wdone(n);
      `CHK(dac, rows[i].lvl)
      if (rows[i].div != 0)
        `CHK(n inside {[11*rows[i].div-6:11*rows[i].div+8]}, 1'b1)
      apb(1'b0, CTRL_OFFSET, 8'h00);
      `CHK(rdata[1:0], 2'b01)
      apb(1'b0, RESULT_HIGH_OFFSET, 8'h00);
      `CHK(rdata[7:0] & (rows[i].ctl[7] ? 8'h03 : 8'hFF), rows[i].hi)
      apb(1'b0, RESULT_LOW_OFFSET, 8'h00);
      `CHK(rdata[7:0] & (rows[i].ctl[7] ? 8'hFF : 8'hC0), rows[i].lo)
      apb(1'b1, STATUS_OFFSET, 8'h01);
      tick(1);
      `CHK(done, 1'b0)
    end
    // abort in mid conversion keeps the old result, then reacquires
    apb(1'b1, CLKSEL_OFFSET, 8'h10);
    level <= 10'h3FF;
    apb(1'b1, CTRL_OFFSET, 8'h0F);
    tick(30);
    apb(1'b1, CTRL_OFFSET, 8'h0D);
    tick(1);
    `CHK(sample, 1'b0)
    n = 0;
    while (sample !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    `CHK(n inside {[10:40]}, 1'b1)
    apb(1'b0, RESULT_HIGH_OFFSET, 8'h00);
    `CHK(rdata[7:0], 8'h30)
    `CHK(done, 1'b0)
    // switch off, then on with go in the same write
    apb(1'b1, CTRL_OFFSET, 8'h00);
    tick(2);
    `CHK(power, 1'b0)
    apb(1'b1, CTRL_OFFSET, 8'h03);
    apb(1'b0, CTRL_OFFSET, 8'h00);
    `CHK(rdata[1:0], 2'b01)
    `CHK(power, 1'b1)
    // special event trigger starts a conversion in hardware
    tick(20);
    trig <= 1'b1;
    tick(1);
    trig <= 1'b0;
    tick(1);
    `CHK(tres, 1'b1)
    apb(1'b0, CTRL_OFFSET, 8'h00);
    `CHK(rdata[1], 1'b1)
    wdone(n);
    apb(1'b0, RESULT_HIGH_OFFSET, 8'h00);
    `CHK(rdata[7:0], 8'hFF)
    apb(1'b1, STATUS_OFFSET, 8'h01);
    // sleep on the divided clock aborts and powers down
    apb(1'b1, CTRL_OFFSET, 8'h03);
    tick(20);
    sleep <= 1'b1;
    tick(10);
    `CHK(power, 1'b0)
    apb(1'b0, CTRL_OFFSET, 8'h00);
    `CHK(rdata[1:0], 2'b01)
    `CHK(done, 1'b0)
    sleep <= 1'b0;
    // rc clock: extra delay, conversion runs on in sleep and wakes
    apb(1'b1, CLKSEL_OFFSET, 8'h30);
    irq <= 1'b1;
    tick(20);
    apb(1'b1, CTRL_OFFSET, 8'h03);
    tick(1);
    `CHK(sample, 1'b1)
    sleep <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    `CHK(n < 3000, 1'b1)
    sleep <= 1'b0;
    apb(1'b1, STATUS_OFFSET, 8'h01);
    // rc clock with the interrupt off: powered down after completion
    irq <= 1'b0;
    tick(20);
    apb(1'b1, CTRL_OFFSET, 8'h03);
    sleep <= 1'b1;
    wdone(n);
    tick(3);
    `CHK(power, 1'b0)
    apb(1'b0, CTRL_OFFSET, 8'h00);
    `CHK(rdata[1:0], 2'b01)
    sleep <= 1'b0;
    // unused clock select bits, unmapped address
    apb(1'b1, CLKSEL_OFFSET, 8'hFF);
    apb(1'b0, CLKSEL_OFFSET, 8'h00);
    `CHK(rdata, 32'h00000070)
    apb(1'b0, 8'h14, 8'h00);
    `CHK({rerr, rdata}, 33'h000000000 | 33'h100000000)
    // reset in mid conversion, done flag still pending
    apb(1'b1, CLKSEL_OFFSET, 8'h10);
    apb(1'b1, CTRL_OFFSET, 8'h83);
    tick(10);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    `CHK(power, 1'b0)
    chkreset();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
